/* File: rtl/isd_top.sv */
// self-diagnostics supervisor of a flow instrument
// What this block does
// RULE1 - after reset, test program memory once, then working memory, then run
// RULE2 - sum all program memory bytes; nonzero sum means failure
// RULE3 - checksum failure halts everything, led flashes 20 hz, alarm on
// RULE4 - after rom pass, write and read two patterns at every ram location
// RULE5 - ram mismatch halts everything, led flashes 10 hz, alarm on
// RULE6 - fatal alarm output is a steady level; only led shows the type
// RULE7 - non-fatal condition: keep running, led 2 hz, alarm follows condition
// RULE8 - check one working parameter per second against its stored checksum
// RULE9 - after clean pass, compare backups one per second, skipping dirty ones
// RULE10 - after zero command, residual above 5 percent is fatal
// RULE11 - run-time fatal: keep measuring and talking, stop control, send code
// RULE12 - after run-time fatal, refuse parameter writes and commands; the block gates commands only, it has no parameter write input
// RULE13 - unusual condition sends status code saying more data is available
// RULE14 - memory-test fatal pattern holds until next power-up reset
`timescale 1ns/1ps
`default_nettype none
module isd_top (
    input  wire logic                        I_CLK,
    input  wire logic                        I_RESET,
    output logic [isd_pkg::ROM_AW-1:0]       O_ROM_ADDR,
    input  wire logic [7:0]                  I_ROM_DATA,
    output logic [isd_pkg::DB_AW-1:0]       O_DB_ADDR,
    input  wire logic [15:0]                 I_DB_WORK,
    input  wire logic [7:0]                  I_DB_WORK_SUM,
    input  wire logic [15:0]                 I_DB_BACKUP,
    input  wire logic                        I_DB_DIRTY,
    input  wire logic                        I_ZERO_DONE,
    input  wire logic [15:0]                 I_ZERO_RESIDUAL,
    input  wire logic                        I_WARN,
    input  wire logic                        I_CMD_REQ,
    output logic                             O_CMD_ALLOW,
    output logic                             O_RUN,
    output logic                             O_COMM_EN,
    output logic                             O_CTRL_EN,
    output logic                             O_MEAS_EN,
    output logic                             O_LED,
    output logic                             O_ALARM_N_OUT,
    output logic                             O_ALARM_N_OE_N,
    output logic [7:0]                       O_STATUS,
    output logic                             O_STATUS_VALID
);
    import isd_pkg::*;

    typedef enum {S_ROM, S_ROM_LAST, S_ROM_CHECK, S_RAM_WA, S_RAM_RA, S_RAM_CA,
                  S_RAM_WB, S_RAM_RB, S_RAM_CB, S_RUN, S_ROM_FAIL, S_RAM_FAIL,
                  S_RT_FATAL} isd_state_type;

    isd_state_type        state_r;
    logic [ROM_AW-1:0]    rom_addr_r;
    logic [15:0]          rom_sum_r;
    logic [RAM_AW-1:0]    ram_addr_r;
    logic                 ram_we;
    logic [7:0]           ram_wdata;
    logic [7:0]           ram_rdata;
    logic [26:0]          sec_cnt_r;
    logic                 sec_tick;
    logic [DB_AW-1:0]     db_idx_r;
    logic                 db_backup_phase_r;
    logic                 db_err;
    logic                 zero_err;
    logic [7:0]           fatal_code_r;
    logic                 warn_s1_r;
    logic                 warn_s2_r;
    logic                 warn_s3_r;
    logic                 warn_r;
    logic                 warn_d_r;
    logic                 zero_s1_r;
    logic                 zero_s2_r;
    logic                 zero_s3_r;
    logic                 zero_pulse;
    logic                 zero_seen_r;
    logic [26:0]          half_cyc;
    logic                 flash_run;
    logic                 led_flash;
    logic                 fatal;

    // power-up sequence and fatal latching
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            state_r <= S_ROM;
        end else begin
            case (state_r)
                S_ROM: begin
                    if (rom_addr_r == {ROM_AW{1'b1}}) begin
                        state_r <= S_ROM_LAST; // RULE1
                    end
                end
                S_ROM_LAST: begin
                    state_r <= S_ROM_CHECK;
                end
                S_ROM_CHECK: begin
                    if (rom_sum_r != ROM_SUM_GOOD) begin
                        state_r <= S_ROM_FAIL; // RULE2
                    end else begin
                        state_r <= S_RAM_WA; // RULE4
                    end
                end
                S_RAM_WA: begin
                    state_r <= S_RAM_RA;
                end
                S_RAM_RA: begin
                    state_r <= S_RAM_CA;
                end
                S_RAM_CA: begin
                    if (ram_rdata != RAM_PAT_A) begin
                        state_r <= S_RAM_FAIL; // RULE5
                    end else begin
                        state_r <= S_RAM_WB;
                    end
                end
                S_RAM_WB: begin
                    state_r <= S_RAM_RB;
                end
                S_RAM_RB: begin
                    state_r <= S_RAM_CB;
                end
                S_RAM_CB: begin
                    if (ram_rdata != RAM_PAT_B) begin
                        state_r <= S_RAM_FAIL; // RULE5
                    end else if (ram_addr_r == {RAM_AW{1'b1}}) begin
                        state_r <= S_RUN; // RULE1
                    end else begin
                        state_r <= S_RAM_WA;
                    end
                end
                S_RUN: begin
                    if (db_err || zero_err) begin
                        state_r <= S_RT_FATAL; // RULE11
                    end
                end
                // fatal states are sticky until reset
                S_ROM_FAIL: state_r <= S_ROM_FAIL; // RULE14
                S_RAM_FAIL: state_r <= S_RAM_FAIL; // RULE14
                S_RT_FATAL: state_r <= S_RT_FATAL;
                default:    state_r <= S_ROM_FAIL;
            endcase
        end
    end

    // program memory walk and byte sum; rom data assumed valid next cycle
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            rom_addr_r <= '0;
            rom_sum_r  <= 16'h0;
        end else if (state_r == S_ROM || state_r == S_ROM_LAST) begin
            if (state_r == S_ROM) begin
                rom_addr_r <= rom_addr_r + 1'b1;
            end
            if (state_r == S_ROM_LAST || rom_addr_r != '0) begin
                rom_sum_r <= rom_sum_r + {8'h00, I_ROM_DATA}; // RULE2
            end
        end
    end
    assign O_ROM_ADDR = rom_addr_r; // RULE2

    // working memory address step after both patterns pass
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            ram_addr_r <= '0;
        end else if (state_r == S_RAM_CB && ram_rdata == RAM_PAT_B) begin
            ram_addr_r <= ram_addr_r + 1'b1;
        end
    end

    // pattern writes at one location: a then b
    always_comb begin
        ram_we    = (state_r == S_RAM_WA) || (state_r == S_RAM_WB); // RULE4
        ram_wdata = (state_r == S_RAM_WB) ? RAM_PAT_B : RAM_PAT_A;
    end

    isd_ram u_ram (
        .i_clk   (I_CLK),
        .i_we    (ram_we),
        .i_addr  (ram_addr_r),
        .i_wdata (ram_wdata),
        .o_rdata (ram_rdata)
    );

    // one-second tick for parameter checks
    always_ff @(posedge I_CLK) begin
        if (I_RESET || state_r != S_RUN) begin
            sec_cnt_r <= 27'h0;
        end else if (sec_tick) begin
            sec_cnt_r <= 27'h0;
        end else begin
            sec_cnt_r <= sec_cnt_r + 27'h1;
        end
    end
    assign sec_tick = (state_r == S_RUN) && (sec_cnt_r == 27'(CHECK_CYC - 1));

    // database walk: working pass, then backup pass, repeated
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            db_idx_r          <= '0;
            db_backup_phase_r <= 1'b0;
        end else if (sec_tick && !db_err) begin
            db_idx_r <= db_idx_r + 1'b1; // RULE8
            if (db_idx_r == DB_AW'(DB_COUNT - 1)) begin
                db_backup_phase_r <= ~db_backup_phase_r; // RULE9
            end
        end
    end
    assign O_DB_ADDR = db_idx_r;

    // check of the parameter under the walk; dirty backups are skipped
    always_comb begin
        db_err = 1'b0;
        if (sec_tick) begin
            if (!db_backup_phase_r) begin
                db_err = isd_param_sum(I_DB_WORK) != I_DB_WORK_SUM; // RULE8
            end else if (!I_DB_DIRTY) begin
                db_err = I_DB_BACKUP != I_DB_WORK; // RULE9
            end
        end
    end

    // zero-done and warning come from outside: three-stage synchronisers
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            zero_s1_r <= 1'b0;
            zero_s2_r <= 1'b0;
            zero_s3_r <= 1'b0;
            warn_s1_r <= 1'b0;
            warn_s2_r <= 1'b0;
            warn_s3_r <= 1'b0;
        end else begin
            zero_s1_r <= I_ZERO_DONE;
            zero_s2_r <= zero_s1_r;
            zero_s3_r <= zero_s2_r;
            warn_s1_r <= I_WARN;
            warn_s2_r <= warn_s1_r;
            warn_s3_r <= warn_s2_r;
        end
    end
    // rising edge once stages two and three agree high
    assign zero_pulse = zero_s2_r && zero_s3_r && !zero_seen_r;
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            zero_seen_r <= 1'b0;
        end else if (zero_s2_r == zero_s3_r) begin
            zero_seen_r <= zero_s3_r;
        end
    end
    // residual sampled with the zero-done level, held stable by the sensor logic
    assign zero_err = (state_r == S_RUN) && zero_pulse
                      && (I_ZERO_RESIDUAL > ZERO_LIMIT); // RULE10

    // warning level changes only when stages two and three agree
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            warn_r   <= 1'b0;
            warn_d_r <= 1'b0;
        end else begin
            if (warn_s2_r == warn_s3_r) begin
                warn_r <= warn_s3_r;
            end
            warn_d_r <= warn_r;
        end
    end

    // fatal code kept for the host status report
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            fatal_code_r <= ST_OK;
        end else if (state_r == S_RUN && db_err) begin
            fatal_code_r <= db_backup_phase_r ? ST_DB_BACKUP : ST_DB_WORK; // RULE11
        end else if (state_r == S_RUN && zero_err) begin
            fatal_code_r <= ST_ZERO_FAIL; // RULE10
        end
    end

    // status strobe: code on entering run-time fatal, more-data on warning rising edge
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            O_STATUS       <= ST_OK;
            O_STATUS_VALID <= 1'b0;
        end else if (state_r == S_RT_FATAL && fatal_code_r != O_STATUS) begin
            O_STATUS       <= fatal_code_r | ST_MORE_DATA; // RULE13
            O_STATUS_VALID <= 1'b1;
        end else if (state_r == S_RUN && warn_r && !warn_d_r) begin
            O_STATUS       <= ST_WARN | ST_MORE_DATA; // RULE13
            O_STATUS_VALID <= 1'b1;
        end else begin
            O_STATUS_VALID <= 1'b0;
        end
    end

    // flash rate chosen by condition; fatal memory cases take priority
    always_comb begin
        flash_run = 1'b1;
        case (state_r)
            S_ROM_FAIL: half_cyc = 27'(ROM_HALF_CYC); // RULE3
            S_RAM_FAIL: half_cyc = 27'(RAM_HALF_CYC); // RULE5
            S_RT_FATAL: half_cyc = 27'(DB_HALF_CYC);
            default: begin
                half_cyc  = 27'(WARN_HALF_CYC); // RULE7
                flash_run = (state_r == S_RUN) && warn_r;
            end
        endcase
    end

    isd_flash u_flash (
        .i_clk      (I_CLK),
        .i_reset    (I_RESET),
        .i_half_cyc (half_cyc),
        .i_run      (flash_run),
        .o_led      (led_flash)
    );

    assign fatal = (state_r == S_ROM_FAIL) || (state_r == S_RAM_FAIL)
                   || (state_r == S_RT_FATAL) || db_err || zero_err; // RULE6

    // outputs registered; alarm open drain pulls low while active
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            O_LED          <= 1'b0;
            O_ALARM_N_OUT  <= 1'b0;
            O_ALARM_N_OE_N <= 1'b1;
            O_RUN          <= 1'b0;
            O_COMM_EN      <= 1'b0;
            O_CTRL_EN      <= 1'b0;
            O_MEAS_EN      <= 1'b0;
            O_CMD_ALLOW    <= 1'b0;
        end else begin
            O_LED          <= led_flash;
            O_ALARM_N_OUT  <= 1'b0;
            // steady level, not flashed, for fatal; follows warning otherwise
            O_ALARM_N_OE_N <= !(fatal || (state_r == S_RUN && warn_r)); // RULE6 RULE7
            O_RUN          <= (state_r == S_RUN);
            // memory faults silence the link; run-time faults keep it
            O_COMM_EN      <= (state_r == S_RUN) || (state_r == S_RT_FATAL); // RULE3 RULE5 RULE11
            O_CTRL_EN      <= (state_r == S_RUN) && !db_err && !zero_err; // RULE11
            O_MEAS_EN      <= (state_r == S_RUN) || (state_r == S_RT_FATAL); // RULE11
            O_CMD_ALLOW    <= (state_r == S_RUN) && I_CMD_REQ && !db_err && !zero_err; // RULE12
        end
    end
endmodule // isd_top
`default_nettype wire

/* File: rtl/isd_pkg.sv */
// constants and types shared by the self-diagnostics supervisor
package isd_pkg;
    localparam int unsigned CLK_HZ         = 125_000_000;
    // led flash rates in hz; each rate toggles twice per period
    localparam int unsigned ROM_FLASH_HZ   = 20;
    localparam int unsigned RAM_FLASH_HZ   = 10;
    localparam int unsigned DB_FLASH_HZ    = 5;
    localparam int unsigned WARN_FLASH_HZ  = 2;
    localparam int unsigned ROM_HALF_CYC   = CLK_HZ / (2 * ROM_FLASH_HZ);
    localparam int unsigned RAM_HALF_CYC   = CLK_HZ / (2 * RAM_FLASH_HZ);
    localparam int unsigned DB_HALF_CYC    = CLK_HZ / (2 * DB_FLASH_HZ);
    localparam int unsigned WARN_HALF_CYC  = CLK_HZ / (2 * WARN_FLASH_HZ);
    // one parameter check per second
    localparam int unsigned CHECK_PERIOD_S = 1;
    localparam int unsigned CHECK_CYC      = CLK_HZ * CHECK_PERIOD_S;
    // memory geometry
    localparam int unsigned ROM_AW         = 12;
    localparam int unsigned RAM_AW         = 8;
    localparam int unsigned DB_AW          = 6;
    localparam int unsigned DB_COUNT       = 64;
    // expected program memory sum
    localparam logic [15:0] ROM_SUM_GOOD   = 16'h0000;
    // the two working memory patterns
    localparam logic [7:0]  RAM_PAT_A      = 8'h55;
    localparam logic [7:0]  RAM_PAT_B      = 8'haa;
    // residual zero limit: 5 percent of full scale 16'hffff
    localparam logic [15:0] ZERO_FULL      = 16'hffff;
    localparam logic [15:0] ZERO_LIMIT     = 16'h0ccc;
    // status codes sent to host
    localparam logic [7:0]  ST_OK          = 8'h00;
    localparam logic [7:0]  ST_MORE_DATA   = 8'h80;
    localparam logic [7:0]  ST_DB_WORK     = 8'h81;
    localparam logic [7:0]  ST_DB_BACKUP   = 8'h82;
    localparam logic [7:0]  ST_ZERO_FAIL   = 8'h83;
    localparam logic [7:0]  ST_WARN        = 8'h84;

    typedef enum logic [1:0] {ISD_LED_OFF, ISD_LED_ON, ISD_LED_FLASH} isd_led_type;

    // 8-bit checksum of a 16-bit parameter, sum of its bytes
    function automatic logic [7:0] isd_param_sum(input logic [15:0] v);
        return 8'(v[15:8] + v[7:0]);
    endfunction
endpackage

/* File: rtl/isd_ram.sv */
// working memory under test: single port, registered read data
`timescale 1ns/1ps
`default_nettype none
module isd_ram (
    input  wire logic                     i_clk,
    input  wire logic                     i_we,
    input  wire logic [isd_pkg::RAM_AW-1:0] i_addr,
    input  wire logic [7:0]               i_wdata,
    output logic      [7:0]               o_rdata
);
    import isd_pkg::*;
    logic [7:0] mem [0:(1<<RAM_AW)-1];

    // read first, registered: a write cycle returns the old word
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_addr] <= i_wdata;
        end
        o_rdata <= mem[i_addr];
    end
endmodule // isd_ram
`default_nettype wire

/* File: rtl/isd_flash.sv */
// led flash generator with selectable half period
`timescale 1ns/1ps
`default_nettype none
module isd_flash (
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    input  wire logic [26:0] i_half_cyc,
    input  wire logic        i_run,
    output logic             o_led
);
    import isd_pkg::*;
    logic [26:0] cnt_r;

    // free count; led toggles at each half period
    always_ff @(posedge i_clk) begin
        if (i_reset || !i_run) begin
            cnt_r <= 27'h0;
            o_led <= 1'b0;
        end else if (cnt_r >= i_half_cyc - 27'h1) begin
            cnt_r <= 27'h0;
            o_led <= ~o_led;
        end else begin
            cnt_r <= cnt_r + 27'h1;
        end
    end
endmodule // isd_flash
`default_nettype wire

/* File: sim/isd_monitor.sv */
// port checker for the self-diagnostics supervisor
`timescale 1ns/1ps
`default_nettype none
module isd_monitor (
    input wire logic                      I_CLK,
    input wire logic                      I_RESET,
    input wire logic                      I_CMD_REQ,
    input wire logic                      I_WARN,
    input wire logic [isd_pkg::DB_AW-1:0] O_DB_ADDR,
    input wire logic                      O_CMD_ALLOW,
    input wire logic                      O_RUN,
    input wire logic                      O_COMM_EN,
    input wire logic                      O_CTRL_EN,
    input wire logic                      O_MEAS_EN,
    input wire logic                      O_ALARM_N_OUT,
    input wire logic                      O_ALARM_N_OE_N,
    input wire logic [7:0]                O_STATUS,
    input wire logic                      O_STATUS_VALID
);
    import isd_pkg::*;
    logic [15:0] cyc_r;

    // cycles since reset; saturates so a long run never wraps back
    always_ff @(posedge I_CLK) begin
        if (I_RESET) cyc_r <= 16'h0000;
        else if (cyc_r != 16'hffff) cyc_r <= cyc_r + 16'h0001;
    end

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RESET);

    AST_ALARM_PIN_LOW: assert property (O_ALARM_N_OUT == 1'b0)
        else $error("alarm pin data not low");
    AST_HALT_ALL: assert property (!O_ALARM_N_OE_N && !O_COMM_EN |->
        !O_RUN && !O_CTRL_EN && !O_MEAS_EN) else $error("halt leaves activity on");
    AST_MEM_FATAL_HOLDS: assert property (!O_ALARM_N_OE_N && !O_COMM_EN |=>
        !O_ALARM_N_OE_N && !O_COMM_EN) else $error("memory fatal state left");
    AST_RUN_AFTER_TEST: assert property ($rose(O_RUN) |-> cyc_r > 16'h1200)
        else $error("run entered before self test");
    AST_SHUTDOWN_KEEPS_MEAS: assert property (O_COMM_EN && !O_CTRL_EN |->
        O_MEAS_EN && !O_ALARM_N_OE_N) else $error("shutdown stops measuring");
    AST_SHUTDOWN_STICKS: assert property (O_COMM_EN && !O_CTRL_EN |=> !O_CTRL_EN)
        else $error("control back after shutdown");
    AST_FATAL_CODE: assert property ($fell(O_CTRL_EN) && O_COMM_EN |->
        ##[0:3] (O_STATUS_VALID && O_STATUS[7])) else $error("no code on shutdown");
    AST_CMD_REFUSED: assert property (O_CMD_ALLOW |->
        $past(I_CMD_REQ) && $past(O_CTRL_EN)) else $error("command allowed wrongly");
    AST_CMD_GRANT: assert property (I_CMD_REQ && O_CTRL_EN ##1 O_CTRL_EN |-> O_CMD_ALLOW)
        else $error("command not allowed in run");
    AST_WARN_ALARM: assert property ((O_CTRL_EN && I_WARN) [*6] |-> !O_ALARM_N_OE_N)
        else $error("warning without alarm");
    AST_WARN_CLEAR: assert property ((O_CTRL_EN && !I_WARN) [*6] |-> O_ALARM_N_OE_N)
        else $error("alarm stays after warning");
    AST_VALID_PULSE: assert property (O_STATUS_VALID |=> !O_STATUS_VALID)
        else $error("status valid longer than a cycle");
    AST_DB_PACE: assert property ($changed(O_DB_ADDR) |=> $stable(O_DB_ADDR) [*8])
        else $error("parameter index steps too fast");
endmodule // isd_monitor
`default_nettype wire

/* File: sim/isd_host_model.sv */
// host computer model on the status side of the supervisor
`timescale 1ns/1ps
`default_nettype none
module isd_host_model (
    input  wire logic       i_clk,
    input  wire logic       i_reset,
    input  wire logic [7:0] i_status,
    input  wire logic       i_status_valid,
    input  wire logic       i_want_cmd,
    output logic            o_cmd_req,
    output logic [7:0]      o_code_count,
    output logic            o_detail_req
);
    // request is a level held while the user wants it
    always_ff @(posedge i_clk) begin
        if (i_reset) o_cmd_req <= 1'b0;
        else o_cmd_req <= i_want_cmd;
    end

    // a code with the more-data bit makes the host ask for details
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_code_count <= 8'h00;
            o_detail_req <= 1'b0;
        end else begin
            o_detail_req <= i_status_valid & i_status[7];
            if (i_status_valid) o_code_count <= o_code_count + 8'h01;
        end
    end
endmodule // isd_host_model
`default_nettype wire

/* File: sim/isd_top_bench.sv */
// self-checking bench for the self-diagnostics supervisor
`timescale 1ns/1ps
`default_nettype none
module isd_top_bench;
    import isd_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  rom_data = 8'h00;
    logic        warn = 1'b0;
    logic        zero_done = 1'b0;
    logic [15:0] zero_res = 16'h0000;
    logic        want_cmd = 1'b0;
    logic        cmd_req, cmd_allow, run, comm_en, ctrl_en, meas_en, led;
    logic        alarm_out, alarm_oe_n, status_valid, detail_req;
    logic [7:0]  status, code_count;
    logic [11:0] rom_addr;
    logic [5:0]  db_addr;
    logic [7:0]  rom [4096];
    int          mismatches = 0;
    int          samples_checked = 0;

    // 125 mhz clock
    always #4 clk = ~clk;
    // program memory answers one cycle after the address
    always @(posedge clk) rom_data <= rom[rom_addr];

    isd_top u_isd_top (
        .I_CLK(clk), .I_RESET(rst), .O_ROM_ADDR(rom_addr), .I_ROM_DATA(rom_data),
        .O_DB_ADDR(db_addr), .I_DB_WORK({8'h12, 2'b00, db_addr}),
        .I_DB_WORK_SUM(8'h12 + {2'b00, db_addr}), .I_DB_BACKUP({8'h12, 2'b00, db_addr}),
        .I_DB_DIRTY(db_addr[0]), .I_ZERO_DONE(zero_done), .I_ZERO_RESIDUAL(zero_res),
        .I_WARN(warn), .I_CMD_REQ(cmd_req), .O_CMD_ALLOW(cmd_allow), .O_RUN(run),
        .O_COMM_EN(comm_en), .O_CTRL_EN(ctrl_en), .O_MEAS_EN(meas_en), .O_LED(led),
        .O_ALARM_N_OUT(alarm_out), .O_ALARM_N_OE_N(alarm_oe_n), .O_STATUS(status),
        .O_STATUS_VALID(status_valid));
    isd_host_model u_isd_host_model (
        .i_clk(clk), .i_reset(rst), .i_status(status), .i_status_valid(status_valid),
        .i_want_cmd(want_cmd), .o_cmd_req(cmd_req), .o_code_count(code_count),
        .o_detail_req(detail_req));

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // n edges, then a step past them so registered outputs have landed
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic do_reset();
        @(posedge clk) rst <= 1'b1;
        tick(2);
        check("reset outs", {8'h00, run, comm_en, ctrl_en, meas_en, led, status_valid,
              cmd_allow, alarm_oe_n}, 16'h0001);
        check("alarm data", {15'h0000, alarm_out}, 16'h0000);
        @(posedge clk) rst <= 1'b0;
    endtask

    // bounded wait: status pulse, or end of self test either way
    task automatic wait_done(input bit want_valid, input int bound, output int n);
        n = 0;
        do begin
            tick(1);
            n++;
        end while (!(want_valid ? status_valid === 1'b1 : (run === 1'b1 || alarm_oe_n === 1'b0))
                   && n < bound);
        if (n >= bound) begin
            mismatches++;
            $display("wrong value wait expected event seen timeout");
            give_verdict();
        end
    endtask

    initial begin
        int n;
        logic [6:0] rows [2];
        logic [7:0] cnt0;
        // rows: bad image bit, then run comm ctrl meas alarm_oe_n cmd_allow
        rows[0] = 7'b1_000000;
        rows[1] = 7'b0_111111;
        // 256 x ff plus 256 x 01 wraps the 16-bit sum to zero exactly
        for (int i = 0; i < 4096; i++) rom[i] = (i < 256) ? 8'hff : (i < 512) ? 8'h01 : 8'h00;
        foreach (rows[r]) begin
            rom[4095] = {7'h00, rows[r][6]};
            do_reset();
            wait_done(1'b0, 8000, n);
            check("test length", {15'h0000, n > (rows[r][6] ? 4096 : 4608)}, 16'h0001);
            @(posedge clk) want_cmd <= 1'b1;
            tick(4);
            check("state", {10'h000, run, comm_en, ctrl_en, meas_en, alarm_oe_n, cmd_allow},
                  {10'h000, rows[r][5:0]});
            tick(2000);
            check("state held", {10'h000, run, comm_en, ctrl_en, meas_en, alarm_oe_n, cmd_allow},
                  {10'h000, rows[r][5:0]});
            check("led", {15'h0000, led}, 16'h0000);
            @(posedge clk) want_cmd <= 1'b0;
        end
        // non-fatal warning while running, then its removal
        cnt0 = code_count;
        @(posedge clk) warn <= 1'b1;
        wait_done(1'b1, 20, n);
        check("warn code", {8'h00, status}, {8'h00, ST_WARN});
        tick(1);
        check("detail req", {15'h0000, detail_req}, 16'h0001);
        tick(3);
        check("warn run", {12'h000, ctrl_en, meas_en, comm_en, alarm_oe_n}, 16'h000e);
        @(posedge clk) warn <= 1'b0;
        tick(8);
        check("warn clear", {15'h0000, alarm_oe_n}, 16'h0001);
        check("host codes", {15'h0000, code_count != cnt0}, 16'h0001);
        // residual exactly at the limit passes
        @(posedge clk) zero_res <= ZERO_LIMIT;
        zero_done <= 1'b1;
        tick(12);
        @(posedge clk) zero_done <= 1'b0;
        tick(6);
        check("zero at limit", {15'h0000, ctrl_en}, 16'h0001);
        // one step above the limit is a run-time fatal
        @(posedge clk) zero_res <= ZERO_LIMIT + 16'h0001;
        zero_done <= 1'b1;
        wait_done(1'b1, 20, n);
        check("zero code", {8'h00, status}, {8'h00, ST_ZERO_FAIL});
        @(posedge clk) zero_done <= 1'b0;
        want_cmd <= 1'b1;
        tick(6);
        check("shutdown", {12'h000, ctrl_en, meas_en, comm_en, alarm_oe_n}, 16'h0006);
        check("cmd refused", {15'h0000, cmd_allow}, 16'h0000);
        give_verdict();
    end
endmodule // isd_top_bench

bind isd_top isd_monitor u_isd_monitor (
    .I_CLK(I_CLK), .I_RESET(I_RESET), .I_CMD_REQ(I_CMD_REQ), .I_WARN(I_WARN),
    .O_DB_ADDR(O_DB_ADDR), .O_CMD_ALLOW(O_CMD_ALLOW), .O_RUN(O_RUN), .O_COMM_EN(O_COMM_EN),
    .O_CTRL_EN(O_CTRL_EN), .O_MEAS_EN(O_MEAS_EN), .O_ALARM_N_OUT(O_ALARM_N_OUT),
    .O_ALARM_N_OE_N(O_ALARM_N_OE_N), .O_STATUS(O_STATUS), .O_STATUS_VALID(O_STATUS_VALID));
`default_nettype wire
